// ### hw/bmx_arb.sv
// Purpose: Grants one initiator at a time under the selected arbitration mode.
// Assumes: A requester holds its request until done; grant is held while it does.
// Notes: Mode 0 favours low indices, mode 1 high indices, mode 2 rotates.
`timescale 1ns/100ps
module bmx_arb #(
    parameter int N = 5
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // Mode and requests.
    input wire logic [2:0] mode,
    input wire logic [N-1:0] req,
    output logic [N-1:0] gnt_r
);
    logic [N-1:0] gnt_nxt;
    logic [$clog2(N)-1:0] last_r;
    logic [$clog2(N)-1:0] last_nxt;
    int idx;

    // Pick a winner only when the bus is free; reserved codes fall back to mode 0.
    always_comb begin
        gnt_nxt = '0;
        last_nxt = last_r;
        idx = 0;
        if ((gnt_r & req) != '0) begin
            gnt_nxt = gnt_r;
        end else begin
            for (int k = N - 1; k >= 0; k--) begin
                if (mode == bmx_pkg::ARB_MODE2) begin
                    // The last pass (k = 0) wins, so the index just after the
                    // previous grantee gets the highest priority.
                    idx = (int'(last_r) + 1 + k) % N;
                end else if (mode == bmx_pkg::ARB_MODE1) begin
                    idx = N - 1 - k;
                end else begin
                    idx = k;
                end
                if (req[idx]) begin
                    gnt_nxt = '0;
                    gnt_nxt[idx] = 1'b1;
                    last_nxt = idx[$clog2(N)-1:0];
                end
            end
        end
    end

    // Grant register and round-robin pointer.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gnt_r <= '0;
            last_r <= '0;
        end else if (ce) begin
            gnt_r <= gnt_nxt;
            last_r <= last_nxt;
        end
    end
endmodule

// ### hw/bmx_ctrl.sv
// Purpose: Bus matrix configuration register with bus error gating and interrupts.
// Assumes: Initiator and debug-mode inputs come from logic on sys_clk.
// Notes: Bus error outputs lag the unmapped-access pulse by one cycle.
`timescale 1ns/100ps
module bmx_ctrl (
    // Clock, reset and clock enable.
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // Register port.
    input wire logic [bmx_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [bmx_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [bmx_pkg::DATA_W-1:0] reg_rdata_r,
    // Unmapped-access pulses per initiator, and the CPU debug-mode level.
    input wire logic [bmx_pkg::INIT_N-1:0] unmapped,
    input wire logic cpu_debug_mode,
    // Bus error exceptions per initiator.
    output logic [bmx_pkg::INIT_N-1:0] bus_err_r,
    // Arbitration.
    input wire logic [bmx_pkg::INIT_N-1:0] arb_req,
    output logic [bmx_pkg::INIT_N-1:0] arb_gnt_r,
    // CPU data RAM access.
    input wire logic ram_req,
    output logic ram_en_r,
    output logic ram_ack_r,
    // Interrupt.
    output logic irq_r
);
    localparam int N = bmx_pkg::INIT_N;

    logic [N-1:0] err_en_r;
    logic ram_ws_r;
    logic [2:0] arb_sel_r;
    logic [N-1:0] stat_r;
    logic [N-1:0] stat_nxt;
    logic [N-1:0] mask_r;
    logic [N-1:0] raise;
    logic [N-1:0] stat_clr;
    logic [bmx_pkg::DATA_W-1:0] ctrl_word;
    logic wr_ctrl;
    logic wr_stat;
    logic wr_mask;

    // Address decode; writes to unmapped offsets are dropped silently.
    assign wr_ctrl = reg_wr && (reg_addr == bmx_pkg::CTRL_OFF);
    assign wr_stat = reg_wr && (reg_addr == bmx_pkg::STAT_OFF);
    assign wr_mask = reg_wr && (reg_addr == bmx_pkg::MASK_OFF);

    // Control register: only implemented bits exist as flops.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            err_en_r <= bmx_pkg::ERR_EN_RST;
            ram_ws_r <= bmx_pkg::WS_RST;
            arb_sel_r <= bmx_pkg::ARB_RST;
        end else if (ce && wr_ctrl) begin
            err_en_r <= reg_wdata[bmx_pkg::ERR_LSB +: N];
            ram_ws_r <= reg_wdata[bmx_pkg::WS_BIT];
            arb_sel_r <= reg_wdata[bmx_pkg::ARB_LSB +: bmx_pkg::ARB_W];
        end
    end

    // Control read image; unimplemented bits are tied to zero.
    always_comb begin
        ctrl_word = '0;
        ctrl_word[bmx_pkg::ERR_LSB +: N] = err_en_r;
        ctrl_word[bmx_pkg::WS_BIT] = ram_ws_r;
        ctrl_word[bmx_pkg::ARB_LSB +: bmx_pkg::ARB_W] = arb_sel_r;
    end

    // Per-initiator gating. The CPU paths are quiet in debug mode so that a
    // debugger poking at holes in the map does not trap the halted core.
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_err
            if (gi == bmx_pkg::IDX_CPU_INSTR || gi == bmx_pkg::IDX_CPU_DATA) begin : g_cpu
                assign raise[gi] = unmapped[gi] && err_en_r[gi] && !cpu_debug_mode;
            end else begin : g_other
                assign raise[gi] = unmapped[gi] && err_en_r[gi];
            end
        end
    endgenerate

    // Bus error exception outputs, one cycle after the access.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_err_r <= '0;
        end else if (ce) begin
            bus_err_r <= raise;
        end
    end

    // Sticky status with write-one-to-clear; a new event beats a clear.
    assign stat_clr = wr_stat ? reg_wdata[N-1:0] : '0;
    assign stat_nxt = raise | (stat_r & ~stat_clr);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_r <= '0;
        end else if (ce) begin
            stat_r <= stat_nxt;
        end
    end

    // Interrupt mask.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_r <= '0;
        end else if (ce && wr_mask) begin
            mask_r <= reg_wdata[N-1:0];
        end
    end

    // Interrupt level follows the status and mask flops one cycle later,
    // which keeps the output straight from a flop at the cost of a cycle.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_r <= 1'b0;
        end else if (ce) begin
            irq_r <= |(stat_r & mask_r);
        end
    end

    // Read data: valid in the cycle after the strobe only, zero otherwise.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata_r <= '0;
        end else if (ce) begin
            reg_rdata_r <= '0;
            if (reg_rd) begin
                case (reg_addr)
                    bmx_pkg::CTRL_OFF: reg_rdata_r <= ctrl_word;
                    bmx_pkg::STAT_OFF: reg_rdata_r <= {{(32 - N){1'b0}}, stat_r};
                    bmx_pkg::MASK_OFF: reg_rdata_r <= {{(32 - N){1'b0}}, mask_r};
                    default: reg_rdata_r <= '0;
                endcase
            end
        end
    end

    // Arbiter steered by the arbitration field.
    bmx_arb #(
        .N(N)
    ) u_arb (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .ce(ce),
        .mode(arb_sel_r),
        .req(arb_req),
        .gnt_r(arb_gnt_r)
    );

    // Data RAM wait-state sequencer.
    bmx_ram_ws u_ram_ws (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .ce(ce),
        .ws_en(ram_ws_r),
        .req(ram_req),
        .ram_en_r(ram_en_r),
        .ack_r(ram_ack_r)
    );

    // Checks on the gating, the register image and the arbitration modes.
    a_shared_err_on: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && unmapped[bmx_pkg::IDX_SHARED])
            |=> (bus_err_r[bmx_pkg::IDX_SHARED] == $past(err_en_r[bmx_pkg::IDX_SHARED])))
        else $error("Shared bus error does not follow its enable.");

    a_debug_err_on: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && unmapped[bmx_pkg::IDX_DEBUG])
            |=> (bus_err_r[bmx_pkg::IDX_DEBUG] == $past(err_en_r[bmx_pkg::IDX_DEBUG])))
        else $error("Debug unit error does not follow its enable.");

    a_dma_err_on: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && unmapped[bmx_pkg::IDX_DMA])
            |=> (bus_err_r[bmx_pkg::IDX_DMA] == $past(err_en_r[bmx_pkg::IDX_DMA])))
        else $error("DMA error does not follow its enable.");

    a_cpu_data_err: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && unmapped[bmx_pkg::IDX_CPU_DATA])
            |=> (bus_err_r[bmx_pkg::IDX_CPU_DATA]
                == ($past(err_en_r[bmx_pkg::IDX_CPU_DATA]) && !$past(cpu_debug_mode))))
        else $error("CPU data error gating wrong.");

    a_cpu_instr_err: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && unmapped[bmx_pkg::IDX_CPU_INSTR])
            |=> (bus_err_r[bmx_pkg::IDX_CPU_INSTR]
                == ($past(err_en_r[bmx_pkg::IDX_CPU_INSTR]) && !$past(cpu_debug_mode))))
        else $error("CPU instruction error gating wrong.");

    a_no_err_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && !unmapped[bmx_pkg::IDX_SHARED]) |=> !bus_err_r[bmx_pkg::IDX_SHARED])
        else $error("Bus error raised without an unmapped access.");

    a_ctrl_read_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && reg_rd && reg_addr == bmx_pkg::CTRL_OFF)
            |=> ((reg_rdata_r & ~bmx_pkg::CTRL_IMPL) == '0)
                && (reg_rdata_r == $past(ctrl_word)))
        else $error("Control read shows unimplemented bits or wrong value.");

    a_ctrl_reset_val: assert property (@(posedge sys_clk)
        $rose(arst_n) |-> (ctrl_word == 32'h001f_0041))
        else $error("Control register reset value wrong.");

    a_mode0_prio: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && arb_sel_r == bmx_pkg::ARB_MODE0 && arb_gnt_r == '0 && arb_req[0])
            |=> arb_gnt_r[0])
        else $error("Mode 0 did not favour the lowest index.");

    a_mode1_prio: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && arb_sel_r == bmx_pkg::ARB_MODE1 && arb_gnt_r == '0 && arb_req[N-1])
            |=> arb_gnt_r[N-1])
        else $error("Mode 1 did not favour the highest index.");

    a_grant_onehot: assert property (@(posedge sys_clk) disable iff (!arst_n)
        $onehot0(arb_gnt_r) && ((arb_gnt_r & ~$past(arb_req)) == '0 || !$past(ce)))
        else $error("Grant not one-hot or not requested.");

    a_stat_set_wins: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && raise[0] && wr_stat && reg_wdata[0]) |=> stat_r[0] ##1 (irq_r || !mask_r[0]
            || !$past(ce)))
        else $error("Status event lost to a simultaneous clear.");

    // No bus error is raised in the cycle after one with no unmapped access at all.
    a_err_quiet_all: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && (unmapped == '0)) |=> (bus_err_r == '0))
        else $error("Bus error raised with no unmapped access.");

    // Debug mode silences both CPU paths whatever the enables say.
    a_debug_cpu_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && cpu_debug_mode)
            |=> (!bus_err_r[bmx_pkg::IDX_CPU_DATA] && !bus_err_r[bmx_pkg::IDX_CPU_INSTR]))
        else $error("CPU bus error raised in debug mode.");

    // A control write lands on the implemented bits only.
    a_ctrl_write_lands: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && wr_ctrl) |=> (ctrl_word == ($past(reg_wdata) & bmx_pkg::CTRL_IMPL)))
        else $error("Control write did not land on the implemented bits.");

    // Without a write, or with the clock enable low, the control image holds.
    a_ctrl_holds: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (!ce || !wr_ctrl) |=> (ctrl_word == $past(ctrl_word)))
        else $error("Control register changed without a write.");

    // Read data stands only in the cycle after a read strobe.
    a_rdata_idle_zero: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && !reg_rd) |=> (reg_rdata_r == '0))
        else $error("Read data shown without a read strobe.");

    // The mask takes the written bits.
    a_mask_write_lands: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && wr_mask) |=> (mask_r == $past(reg_wdata[N-1:0])))
        else $error("Mask write did not land.");

    // Status only gathers events while nobody clears it.
    a_stat_sticky: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && !wr_stat) |=> (stat_r == ($past(stat_r) | $past(raise))))
        else $error("Status bits lost without a clear.");

    // The interrupt level follows the masked status one cycle later.
    a_irq_level: assert property (@(posedge sys_clk) disable iff (!arst_n)
        ce |=> (irq_r == $past(|(stat_r & mask_r))))
        else $error("Interrupt level does not follow masked status.");

    // A grant is kept while its holder still requests.
    a_grant_held: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && ((arb_gnt_r & arb_req) != '0)) |=> (arb_gnt_r == $past(arb_gnt_r)))
        else $error("Grant taken from a holder that still requests.");
endmodule

// ### hw/bmx_pkg.sv
// Purpose: Constants shared by the bus matrix configuration block.
// Assumes: One 100 MHz system clock; registers are word aligned on a plain port.
// Notes: Bit positions follow the control register layout.
package bmx_pkg;
    // Register port geometry and offsets.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STAT_OFF = 8'h04;
    localparam logic [7:0] MASK_OFF = 8'h08;
    // Initiator indices, in the order of the error enable bits.
    localparam int INIT_N = 5;
    localparam int IDX_CPU_INSTR = 0;
    localparam int IDX_CPU_DATA = 1;
    localparam int IDX_DMA = 2;
    localparam int IDX_DEBUG = 3;
    localparam int IDX_SHARED = 4;
    // Field positions in the control register.
    localparam int ERR_LSB = 16;
    localparam int WS_BIT = 6;
    localparam int ARB_LSB = 0;
    localparam int ARB_W = 3;
    // Reset values and implemented-bit mask.
    localparam logic [4:0] ERR_EN_RST = 5'h1f;
    localparam logic WS_RST = 1'b1;
    localparam logic [2:0] ARB_RST = 3'h1;
    localparam logic [31:0] CTRL_IMPL = 32'h001f_0047;
    // Arbitration codes.
    localparam logic [2:0] ARB_MODE0 = 3'h0;
    localparam logic [2:0] ARB_MODE1 = 3'h1;
    localparam logic [2:0] ARB_MODE2 = 3'h2;
endpackage

// ### hw/bmx_ram_ws.sv
// Purpose: Inserts the optional address-setup wait state on CPU data RAM accesses.
// Assumes: A request is a one-cycle pulse; a pulse while busy is ignored.
// Notes: Acknowledge and RAM enable share the same cycle.
`timescale 1ns/100ps
module bmx_ram_ws (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic ce,
    // Control.
    input wire logic ws_en,
    // CPU side.
    input wire logic req,
    output logic ram_en_r,
    output logic ack_r
);
    typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_ACCESS} bmx_ws_state_t;
    bmx_ws_state_t state_r;

    // Setup cycle is taken only when the wait-state bit is set.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            ram_en_r <= 1'b0;
            ack_r <= 1'b0;
        end else if (ce) begin
            ram_en_r <= 1'b0;
            ack_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (req && ws_en) begin
                        state_r <= ST_SETUP;
                    end else if (req) begin
                        ram_en_r <= 1'b1;
                        ack_r <= 1'b1;
                    end
                end
                ST_SETUP: begin
                    state_r <= ST_IDLE;
                    ram_en_r <= 1'b1;
                    ack_r <= 1'b1;
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    a_zero_wait_ack: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && req && !ws_en && state_r == ST_IDLE) |=> ack_r)
        else $error("Zero wait access not acknowledged next cycle.");
    a_one_wait_ack: assert property (@(posedge sys_clk) disable iff (!arst_n)
        (ce && req && ws_en && state_r == ST_IDLE) |=> !ack_r ##1 (ack_r || !$past(ce)))
        else $error("Setup wait state not inserted.");
endmodule

// ### verification/bmx_init_model.sv
// Purpose: Behavioural bus initiators that request the matrix and hold until served.
// Assumes: Grants are one-hot and come from the matrix on sys_clk.
// Notes: Each served requester keeps its request for two granted edges, then lets go.
`timescale 1ns/100ps
module bmx_init_model (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic arst_n,
    // Start pulses from the bench and grants from the matrix.
    input wire logic [4:0] start,
    input wire logic [4:0] gnt,
    // Requests to the matrix.
    output logic [4:0] req_r
);
    logic [1:0] held_r;

    // A request is dropped only after its grant, so the matrix never loses a holder early.
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            req_r <= 5'h00;
            held_r <= 2'h0;
        end else if ((gnt & req_r) != 5'h00) begin
            held_r <= (held_r == 2'h1) ? 2'h0 : held_r + 2'h1;
            req_r <= (held_r == 2'h1) ? (req_r & ~gnt) : req_r;
        end else begin
            req_r <= req_r | start;
        end
    end
endmodule

// ### verification/testbench.sv
// Purpose: Self-checking bench for the bus matrix configuration block.
// Assumes: Register reads answer one cycle after the strobe, with no wait.
// Notes: Arbitration order is judged from the sequence of new grants.
`timescale 1ns/100ps
module testbench;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata_r;
    logic [4:0] unmapped = 5'h00;
    logic cpu_debug_mode = 1'b0;
    logic [4:0] bus_err_r, arb_req, arb_gnt_r, prev_gnt, start = 5'h00;
    logic ram_req = 1'b0;
    logic ram_en_r, ram_ack_r, irq_r;
    logic [31:0] rdat;
    logic [4:0] order[$];
    int err_count = 0;
    int cmp_count = 0;

    bmx_ctrl i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
        .unmapped(unmapped), .cpu_debug_mode(cpu_debug_mode), .bus_err_r(bus_err_r),
        .arb_req(arb_req), .arb_gnt_r(arb_gnt_r), .ram_req(ram_req), .ram_en_r(ram_en_r),
        .ram_ack_r(ram_ack_r), .irq_r(irq_r));
    bmx_init_model i_init (.sys_clk(sys_clk), .arst_n(arst_n), .start(start),
        .gnt(arb_gnt_r), .req_r(arb_req));

    // The clock toggles every 5 ns, half of its 10 ns period.
    always #5 sys_clk = ~sys_clk;

    // Each new grant is logged so that the serving order can be judged later.
    always @(posedge sys_clk) begin
        if (arb_gnt_r !== prev_gnt && arb_gnt_r !== 5'h00)
            order.push_back(arb_gnt_r);
        prev_gnt <= arb_gnt_r;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // Read data is taken only in the cycle after the strobe, where it stands.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata_r;
    endtask

    task automatic err_pulse(input int i, input logic [4:0] exp);
        @(posedge sys_clk);
        unmapped <= 5'h01 << i;
        @(posedge sys_clk);
        unmapped <= 5'h00;
        #1 chk(32'(bus_err_r), 32'(exp));
    endtask

    task automatic test_regs();
        rd(bmx_pkg::CTRL_OFF, rdat);
        chk(rdat, 32'h001f_0041);
        // A write with the clock enable low must leave the register alone.
        @(posedge sys_clk);
        ce <= 1'b0;
        wr(bmx_pkg::CTRL_OFF, 32'h0000_0000);
        ce <= 1'b1;
        rd(bmx_pkg::CTRL_OFF, rdat);
        chk(rdat, 32'h001f_0041);
        wr(bmx_pkg::CTRL_OFF, 32'hffff_fffa);
        rd(bmx_pkg::CTRL_OFF, rdat);
        chk(rdat, 32'h001f_0042);
        wr(bmx_pkg::CTRL_OFF, 32'h0000_0000);
        rd(bmx_pkg::CTRL_OFF, rdat);
        chk(rdat, 32'h0000_0000);
        wr(8'h0c, 32'hffff_ffff);
        rd(8'h0c, rdat);
        chk(rdat, 32'h0000_0000);
    endtask

    // Only the initiator whose enable is set may see its bus error.
    task automatic test_enables();
        for (int i = 0; i < 5; i++) begin
            wr(bmx_pkg::CTRL_OFF, 32'h41 | (32'h1 << (16 + i)));
            for (int j = 0; j < 5; j++)
                err_pulse(j, (i == j) ? (5'h01 << j) : 5'h00);
        end
        wr(bmx_pkg::STAT_OFF, 32'h1f);
    endtask

    task automatic test_debug();
        wr(bmx_pkg::CTRL_OFF, 32'h001f_0041);
        @(posedge sys_clk);
        cpu_debug_mode <= 1'b1;
        err_pulse(0, 5'h00);
        err_pulse(1, 5'h00);
        err_pulse(2, 5'h04);
        @(posedge sys_clk);
        cpu_debug_mode <= 1'b0;
        err_pulse(1, 5'h02);
        wr(bmx_pkg::STAT_OFF, 32'h1f);
    endtask

    // A masked event must not raise the line; clearing drops it again.
    task automatic test_irq();
        wr(bmx_pkg::MASK_OFF, 32'h04);
        err_pulse(1, 5'h02);
        repeat (2) @(posedge sys_clk);
        #1 chk(32'(irq_r), 32'h0);
        err_pulse(2, 5'h04);
        @(posedge sys_clk);
        #1 chk(32'(irq_r), 32'h1);
        rd(bmx_pkg::STAT_OFF, rdat);
        chk(rdat, 32'h06);
        wr(bmx_pkg::STAT_OFF, 32'h04);
        repeat (2) @(posedge sys_clk);
        #1 chk(32'(irq_r), 32'h0);
        rd(bmx_pkg::STAT_OFF, rdat);
        chk(rdat, 32'h02);
        wr(bmx_pkg::STAT_OFF, 32'h02);
        // An event in the same cycle as its clear must survive.
        @(posedge sys_clk);
        unmapped <= 5'h01;
        reg_addr <= bmx_pkg::STAT_OFF;
        reg_wdata <= 32'h01;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        unmapped <= 5'h00;
        reg_wr <= 1'b0;
        rd(bmx_pkg::STAT_OFF, rdat);
        chk(rdat, 32'h01);
        wr(bmx_pkg::STAT_OFF, 32'h01);
    endtask

    task automatic test_ram(input logic ws);
        wr(bmx_pkg::CTRL_OFF, 32'h001f_0001 | (32'(ws) << 6));
        @(posedge sys_clk);
        ram_req <= 1'b1;
        @(posedge sys_clk);
        ram_req <= 1'b0;
        #1 chk(32'({ram_en_r, ram_ack_r}), 32'({2{~ws}}));
        @(posedge sys_clk);
        #1 chk(32'({ram_en_r, ram_ack_r}), 32'({2{ws}}));
    endtask

    // Two initiators request together; the mode decides who is served first.
    task automatic test_arb(input logic [2:0] m, input logic [4:0] a, input logic [4:0] b);
        wr(bmx_pkg::CTRL_OFF, 32'h001f_0040 | 32'(m));
        order.delete();
        @(posedge sys_clk);
        start <= 5'h05;
        @(posedge sys_clk);
        start <= 5'h00;
        repeat (30) @(posedge sys_clk);
        chk(32'(order.size()), 32'h2);
        if (order.size() == 2)
            chk(32'({order[0], order[1]}), 32'({a, b}));
    endtask

    task automatic end_sim();
        if (err_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Only the defined arbitration codes are ever written here.
    initial begin
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        test_regs();
        test_enables();
        test_debug();
        test_irq();
        test_ram(1'b1);
        test_ram(1'b0);
        test_arb(bmx_pkg::ARB_MODE1, 5'h04, 5'h01);
        test_arb(bmx_pkg::ARB_MODE2, 5'h04, 5'h01);
        test_arb(bmx_pkg::ARB_MODE0, 5'h01, 5'h04);
        end_sim();
    end

    // The tests need a few hundred cycles; this bound of 20000 cycles is far beyond that.
    initial begin
        #200000;
        err_count++;
        end_sim();
    end
endmodule
